/* File: hw/sar_reporter.sv */
// health attribute reporter with task file registers on ahb-lite
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "sar_defines.svh"
module sar_reporter
   import sar_pkg::*;
#(
   parameter int NCHIPS = 4
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output      logic [31:0]       hrdata,
   output      logic              hreadyout,
   output      logic              hresp,
   // flash management events, one-cycle pulses
   input  wire logic              ecc_corr_evt,
   input  wire logic              ecc_uncorr_evt,
   input  wire logic              flash_read_evt,
   input  wire logic              crc_err_evt,
   // flash management figures
   input  wire logic [NCHIPS*16-1:0] spare_init,
   input  wire logic [NCHIPS*16-1:0] spare_cur,
   input  wire logic [63:0]       erase_total,
   input  wire logic [63:0]       erase_budget
);
   if (NCHIPS < 1 || NCHIPS > 255) begin : g_bad_nchips
      $error("NCHIPS out of range");
   end

   sar_eval_if ev_if ();

   sar_health_eval #(.NCHIPS(NCHIPS)) u_eval (
      .sys_clk      (sys_clk),
      .arst_n       (arst_n),
      .spare_init   (spare_init),
      .spare_cur    (spare_cur),
      .erase_total  (erase_total),
      .erase_budget (erase_budget),
      .ev           (ev_if.eval)
   );

   // task file and control state
   logic [7:0]  feature_reg, feature_next;
   logic [7:0]  cyl_lo_reg, cyl_lo_next;
   logic [7:0]  cyl_hi_reg, cyl_hi_next;
   logic [7:0]  drvhead_reg, drvhead_next;
   logic [7:0]  spare_thr_reg, spare_thr_next;
   logic [7:0]  erase_thr_reg, erase_thr_next;
   logic        drq_reg, drq_next;
   logic        err_reg, err_next;
   logic        exc_reg, exc_next;
   sar_mode_t   mode_reg, mode_next;
   logic [6:0]  word_reg, word_next;
   logic [7:0]  acc_reg, acc_next;
   // ahb state
   logic        wr_pend_reg, wr_pend_next;
   logic [7:0]  wr_addr_reg, wr_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   // counters and snapshot
   logic [31:0] cnt_ecc_reg, cnt_ecc_next;
   logic [31:0] cnt_corr_reg, cnt_corr_next;
   logic [31:0] cnt_rd_reg, cnt_rd_next;
   logic [31:0] cnt_crc_reg, cnt_crc_next;
   logic [31:0] s_cnt_reg [4];
   logic [31:0] s_cnt_next [4];
   logic [63:0] s_spare_reg, s_spare_next;
   logic [63:0] s_erase_reg, s_erase_next;
   logic [7:0]  s_spct_reg, s_spct_next;
   logic [7:0]  s_life_reg, s_life_next;

   logic        accept;
   logic        pop;
   logic        exceeded;
   logic        cmd_ok;

   assign accept = hsel & hready & htrans[1];
   assign pop    = accept & ~hwrite & (haddr[7:0] == `SAR_A_DATA) & drq_reg;
   // only the spare and erase attributes enter the status decision
   assign exceeded = (ev_if.spare_pct < spare_thr_reg)
                   | (ev_if.life_pct < erase_thr_reg);
   // the command is taken only with the signature and drive/head top bits
   assign cmd_ok = (hwdata[7:0] == `SAR_CMD_SMART)
                 & (cyl_lo_reg == `SAR_SIG_LO) & (cyl_hi_reg == `SAR_SIG_HI)
                 & (drvhead_reg[7:5] == `SAR_DH_TOP);

   function automatic sar_byte_t rec_id(input logic [2:0] rec);
      unique case (rec)
         3'd0:    return `SAR_ID_SPARE;
         3'd1:    return `SAR_ID_ERASE;
         3'd2:    return `SAR_ID_ECC_ALL;
         3'd3:    return `SAR_ID_ECC_CORR;
         3'd4:    return `SAR_ID_READS;
         default: return `SAR_ID_CRC;
      endcase
   endfunction : rec_id

   // one byte of the outgoing sector, from the snapshot or, in threshold mode, from the threshold registers
   function automatic sar_byte_t sec_byte(input logic [8:0] idx);
      logic [8:0]  off;
      logic [2:0]  rec;
      logic [3:0]  k;
      logic [63:0] pl;
      sar_byte_t   b;
      off = idx - `SAR_REC_FIRST;
      rec = 3'(off / `SAR_REC_LEN);
      k   = 4'(off % `SAR_REC_LEN);
      b   = 8'h00;
      unique case (rec)
         3'd0:    pl = s_spare_reg;
         3'd1:    pl = s_erase_reg;
         default: pl = {32'h0, s_cnt_reg[2'(rec - 3'd2)]};
      endcase
      if (idx == 9'h000) b = `SAR_VERSION_LO;
      else if (idx >= `SAR_REC_FIRST && idx < `SAR_REC_END) begin
         if (mode_reg == SAR_THR) begin
            if (k == 4'd0) b = rec_id(rec);
            else if (k == 4'd1 && rec == 3'd0) b = spare_thr_reg;
            else if (k == 4'd1 && rec == 3'd1) b = erase_thr_reg;
         end else begin
            unique case (k)
               4'd0: b = rec_id(rec);
               4'd1: b = (rec < 3'd2) ? `SAR_FLAGS_PREFAIL
                                      : `SAR_FLAGS_ADVIS;
               4'd2: b = 8'h00;
               4'd3: b = (rec == 3'd0) ? s_spct_reg
                       : (rec == 3'd1) ? s_life_reg
                       : `SAR_VALUE_FIXED;
               default: b = pl[8*(k - 4'd4) +: 8];
            endcase
         end
      end
      return b;
   endfunction : sec_byte

   // event counters
   always_comb begin
      cnt_ecc_next  = cnt_ecc_reg + 32'((ecc_corr_evt | ecc_uncorr_evt));
      cnt_corr_next = cnt_corr_reg + 32'(ecc_corr_evt);
      cnt_rd_next   = cnt_rd_reg + 32'(flash_read_evt);
      cnt_crc_next  = cnt_crc_reg + 32'(crc_err_evt);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ecc_reg  <= 32'h0;
         cnt_corr_reg <= 32'h0;
         cnt_rd_reg   <= 32'h0;
         cnt_crc_reg  <= 32'h0;
      end else begin
         cnt_ecc_reg  <= cnt_ecc_next;
         cnt_corr_reg <= cnt_corr_next;
         cnt_rd_reg   <= cnt_rd_next;
         cnt_crc_reg  <= cnt_crc_next;
      end
   end

   // bus, task file and sector transfer
   always_comb begin
      sar_byte_t b0, b1, b2, b3;
      logic [8:0] base;
      base = {word_reg, 2'b00};
      b0 = sec_byte(base);
      b1 = sec_byte(base + 9'd1);
      b2 = sec_byte(base + 9'd2);
      b3 = sec_byte(base + 9'd3);
      if (word_reg == `SAR_LAST_WORD) b3 = 8'(8'h00 - acc_reg - b0 - b1 - b2);
      feature_next   = feature_reg;
      cyl_lo_next    = cyl_lo_reg;
      cyl_hi_next    = cyl_hi_reg;
      drvhead_next   = drvhead_reg;
      spare_thr_next = spare_thr_reg;
      erase_thr_next = erase_thr_reg;
      drq_next       = drq_reg;
      err_next       = err_reg;
      exc_next       = exc_reg;
      mode_next      = mode_reg;
      word_next      = word_reg;
      acc_next       = acc_reg;
      s_cnt_next     = s_cnt_reg;
      s_spare_next   = s_spare_reg;
      s_erase_next   = s_erase_reg;
      s_spct_next    = s_spct_reg;
      s_life_next    = s_life_reg;
      wr_pend_next   = accept & hwrite;
      wr_addr_next   = haddr[7:0];
      hrdata_next    = 32'h0;
      if (accept && !hwrite) begin
         unique case (haddr[7:0])
            `SAR_A_FEATURE:   hrdata_next = {24'h0, feature_reg};
            `SAR_A_CYL_LO:    hrdata_next = {24'h0, cyl_lo_reg};
            `SAR_A_CYL_HI:    hrdata_next = {24'h0, cyl_hi_reg};
            `SAR_A_DRVHEAD:   hrdata_next = {24'h0, drvhead_reg};
            `SAR_A_STATUS:    hrdata_next = {29'h0, exc_reg, err_reg, drq_reg};
            `SAR_A_SPARE_THR: hrdata_next = {24'h0, spare_thr_reg};
            `SAR_A_ERASE_THR: hrdata_next = {24'h0, erase_thr_reg};
            default:          hrdata_next = 32'h0;
         endcase
      end
      if (pop) begin
         hrdata_next = {b3, b2, b1, b0};
         acc_next    = 8'(acc_reg + b0 + b1 + b2 + b3);
         word_next   = 7'(word_reg + 7'd1);
         if (word_reg == `SAR_LAST_WORD) begin
            drq_next  = 1'b0;
            mode_next = SAR_IDLE;
         end
      end
      if (wr_pend_reg) begin
         unique case (wr_addr_reg)
            `SAR_A_FEATURE:   feature_next   = hwdata[7:0];
            `SAR_A_CYL_LO:    cyl_lo_next    = hwdata[7:0];
            `SAR_A_CYL_HI:    cyl_hi_next    = hwdata[7:0];
            `SAR_A_DRVHEAD:   drvhead_next   = hwdata[7:0];
            `SAR_A_SPARE_THR: spare_thr_next = hwdata[7:0];
            `SAR_A_ERASE_THR: erase_thr_next = hwdata[7:0];
            `SAR_A_COMMAND: begin
               err_next  = 1'b0;
               drq_next  = 1'b0;
               mode_next = SAR_IDLE;
               if (!cmd_ok) err_next = 1'b1;
               else if (feature_reg == `SAR_FEAT_STATUS) begin
                  exc_next    = exceeded;
                  cyl_lo_next = exceeded ? `SAR_EXC_LO : `SAR_SIG_LO;
                  cyl_hi_next = exceeded ? `SAR_EXC_HI : `SAR_SIG_HI;
               end else if (feature_reg == `SAR_FEAT_RD_DATA ||
                            feature_reg == `SAR_FEAT_RD_THR) begin
                  mode_next = (feature_reg == `SAR_FEAT_RD_THR) ? SAR_THR
                                                                : SAR_DATA;
                  drq_next  = 1'b1;
                  word_next = 7'h00;
                  acc_next  = 8'h00;
                  exc_next  = exceeded;
                  s_cnt_next[0] = cnt_ecc_reg;
                  s_cnt_next[1] = cnt_corr_reg;
                  s_cnt_next[2] = cnt_rd_reg;
                  s_cnt_next[3] = cnt_crc_reg;
                  s_spare_next  = {ev_if.sum_cur, ev_if.sum_init,
                                   ev_if.sel_cur, ev_if.sel_init};
                  s_erase_next  = erase_total;
                  s_spct_next   = ev_if.spare_pct;
                  s_life_next   = ev_if.life_pct;
               end else err_next = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         feature_reg   <= 8'h00;
         cyl_lo_reg    <= 8'h00;
         cyl_hi_reg    <= 8'h00;
         drvhead_reg   <= 8'h00;
         spare_thr_reg <= 8'h00;
         erase_thr_reg <= 8'h00;
         drq_reg       <= 1'b0;
         err_reg       <= 1'b0;
         exc_reg       <= 1'b0;
         mode_reg      <= SAR_IDLE;
         word_reg      <= 7'h00;
         acc_reg       <= 8'h00;
         wr_pend_reg   <= 1'b0;
         wr_addr_reg   <= 8'h00;
         hrdata_reg    <= 32'h0;
         s_cnt_reg     <= '{default: 32'h0};
         s_spare_reg   <= 64'h0;
         s_erase_reg   <= 64'h0;
         s_spct_reg    <= 8'h00;
         s_life_reg    <= 8'h00;
      end else begin
         feature_reg   <= feature_next;
         cyl_lo_reg    <= cyl_lo_next;
         cyl_hi_reg    <= cyl_hi_next;
         drvhead_reg   <= drvhead_next;
         spare_thr_reg <= spare_thr_next;
         erase_thr_reg <= erase_thr_next;
         drq_reg       <= drq_next;
         err_reg       <= err_next;
         exc_reg       <= exc_next;
         mode_reg      <= mode_next;
         word_reg      <= word_next;
         acc_reg       <= acc_next;
         wr_pend_reg   <= wr_pend_next;
         wr_addr_reg   <= wr_addr_next;
         hrdata_reg    <= hrdata_next;
         s_cnt_reg     <= s_cnt_next;
         s_spare_reg   <= s_spare_next;
         s_erase_reg   <= s_erase_next;
         s_spct_reg    <= s_spct_next;
         s_life_reg    <= s_life_next;
      end
   end

   // zero wait states, always okay
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
   assign hrdata = hrdata_reg;

   logic cmd_wr;
   assign cmd_wr = wr_pend_reg && wr_addr_reg == `SAR_A_COMMAND && cmd_ok;

   property p_status_exc;
      @(posedge sys_clk) disable iff (!arst_n)
      (cmd_wr && feature_reg == `SAR_FEAT_STATUS && exceeded)
         |=> cyl_lo_reg == 8'hf4 && cyl_hi_reg == 8'h2c && exc_reg;
   endproperty
   a_status_exc: assert property (p_status_exc)
      else $error("exceeded status not signalled");

   property p_status_ok;
      @(posedge sys_clk) disable iff (!arst_n)
      (cmd_wr && feature_reg == `SAR_FEAT_STATUS && !exceeded)
         |=> cyl_lo_reg == 8'h4f && cyl_hi_reg == 8'hc2 && !exc_reg;
   endproperty
   a_status_ok: assert property (p_status_ok)
      else $error("good status not signalled");

   property p_spare_exc;
      @(posedge sys_clk) disable iff (!arst_n)
      (cmd_wr && feature_reg == `SAR_FEAT_STATUS
         && ev_if.spare_pct < spare_thr_reg)
         |=> exc_reg && cyl_lo_reg == 8'hf4;
   endproperty
   a_spare_exc: assert property (p_spare_exc)
      else $error("spare below threshold not exceeded");

   property p_sector_len;
      @(posedge sys_clk) disable iff (!arst_n)
      (pop && word_reg == 7'h7f) |=> !drq_reg ##1 !drq_reg;
   endproperty
   a_sector_len: assert property (p_sector_len)
      else $error("transfer does not stop after one sector");

   property p_checksum;
      @(posedge sys_clk) disable iff (!arst_n)
      (pop && word_reg == 7'h7f) |=> acc_reg == 8'h00;
   endproperty
   a_checksum: assert property (p_checksum)
      else $error("sector byte sum not zero");

   property p_first_word;
      @(posedge sys_clk) disable iff (!arst_n)
      (pop && word_reg == 7'h00)
         |=> hrdata_reg[7:0] == 8'h04 && hrdata_reg[23:16] == `SAR_ID_SPARE;
   endproperty
   a_first_word: assert property (p_first_word)
      else $error("first word lacks version or spare id");

   property p_ecc_count;
      @(posedge sys_clk) disable iff (!arst_n)
      (ecc_corr_evt || ecc_uncorr_evt)
         |=> cnt_ecc_reg == $past(cnt_ecc_reg) + 32'h1;
   endproperty
   a_ecc_count: assert property (p_ecc_count)
      else $error("ecc error not counted");

   property p_corr_count;
      @(posedge sys_clk) disable iff (!arst_n)
      !ecc_corr_evt |=> cnt_corr_reg == $past(cnt_corr_reg);
   endproperty
   a_corr_count: assert property (p_corr_count)
      else $error("correctable count moved without event");

   property p_read_count;
      @(posedge sys_clk) disable iff (!arst_n)
      flash_read_evt ##1 !flash_read_evt
         |=> cnt_rd_reg == $past(cnt_rd_reg, 2) + 32'h1;
   endproperty
   a_read_count: assert property (p_read_count)
      else $error("read not counted once");

   property p_crc_count;
      @(posedge sys_clk) disable iff (!arst_n)
      crc_err_evt |=> cnt_crc_reg != $past(cnt_crc_reg);
   endproperty
   a_crc_count: assert property (p_crc_count)
      else $error("crc error not counted");
endmodule : sar_reporter

/* File: hw/sar_defines.svh */
// constants of the health attribute reporter
// Operation
// - spare record byte 0 is c4h
// - spare and erase records carry flags 0003h
// - spare value is minimum chip spare percentage
// - spare record holds chosen and summed spare counts
// - spare value below threshold flags exceeded
// - erase record byte 0 is e5h
// - erase value is remaining life percent
// - erase record bytes 4-11 hold erase total
// - erase value below threshold flags exceeded
// - cbh record counts all ecc errors; corr and uncorr pulses in one cycle count once
// - cch record counts correctable ecc errors
// - e8h record counts flash read commands
// - c7h record counts udma crc errors
// - four counting records carry flags 0002h
// - counting records report fixed value 64h
// - counting records never affect exceeded status
// - threshold read returns exactly one sector
// - status query loads f4h/2ch or 4fh/c2h
// - records are 12-byte entries from byte 2
// - threshold sector: version 0004h, entries, checksum
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH
`define SAR_ID_SPARE      8'hc4
`define SAR_ID_ERASE      8'he5
`define SAR_ID_ECC_ALL    8'hcb
`define SAR_ID_ECC_CORR   8'hcc
`define SAR_ID_READS      8'he8
`define SAR_ID_CRC        8'hc7
`define SAR_FLAGS_PREFAIL 8'h03
`define SAR_FLAGS_ADVIS   8'h02
`define SAR_VALUE_FIXED   8'h64
`define SAR_VERSION_LO    8'h04
`define SAR_CMD_SMART     8'hb0
`define SAR_FEAT_RD_DATA  8'hd0
`define SAR_FEAT_RD_THR   8'hd1
`define SAR_FEAT_STATUS   8'hda
`define SAR_SIG_LO        8'h4f
`define SAR_SIG_HI        8'hc2
`define SAR_EXC_LO        8'hf4
`define SAR_EXC_HI        8'h2c
`define SAR_DH_TOP        3'h7
`define SAR_REC_FIRST     9'h002
`define SAR_REC_LEN       9'h00c
`define SAR_REC_END       9'h04a
`define SAR_LAST_WORD     7'h7f
`define SAR_PERCENT       24'h000064
// register byte offsets
`define SAR_A_FEATURE     8'h00
`define SAR_A_CYL_LO      8'h04
`define SAR_A_CYL_HI      8'h08
`define SAR_A_DRVHEAD     8'h0c
`define SAR_A_COMMAND     8'h10
`define SAR_A_STATUS      8'h14
`define SAR_A_DATA        8'h18
`define SAR_A_SPARE_THR   8'h1c
`define SAR_A_ERASE_THR   8'h20
// status bits
`define SAR_ST_DRQ        0
`define SAR_ST_ERR        1
`define SAR_ST_EXC        2
`endif

/* File: hw/sar_pkg.sv */
// types of the health attribute reporter
package sar_pkg;
   typedef enum {SAR_IDLE, SAR_DATA, SAR_THR} sar_mode_t;
   typedef logic [7:0] sar_byte_t;
endpackage : sar_pkg

/* File: hw/sar_eval_if.sv */
// evaluated health figures passed from the evaluator to the core
`timescale 1ns/1ns
interface sar_eval_if;
   logic [7:0]  spare_pct;
   logic [15:0] sel_init;
   logic [15:0] sel_cur;
   logic [15:0] sum_init;
   logic [15:0] sum_cur;
   logic [7:0]  life_pct;
   modport eval (output spare_pct, sel_init, sel_cur, sum_init, sum_cur,
                 life_pct);
   modport core (input spare_pct, sel_init, sel_cur, sum_init, sum_cur,
                 life_pct);
endinterface : sar_eval_if

/* File: hw/sar_health_eval.sv */
// spare block percentage and remaining life evaluation
`timescale 1ns/1ns
`include "sar_defines.svh"
module sar_health_eval
   import sar_pkg::*;
#(
   parameter int NCHIPS = 4
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   // flash management figures
   input  wire logic [NCHIPS*16-1:0] spare_init,
   input  wire logic [NCHIPS*16-1:0] spare_cur,
   input  wire logic [63:0]       erase_total,
   input  wire logic [63:0]       erase_budget,
   // results
   sar_eval_if.eval               ev
);
   if (NCHIPS < 1 || NCHIPS > 255) begin : g_bad_nchips
      $error("NCHIPS out of range");
   end

   function automatic logic [7:0] pct(input logic [15:0] cur,
                                      input logic [15:0] init);
      logic [23:0] q;
      q = 24'h000000;
      if (init != 16'h0000) q = ({8'h00, cur} * `SAR_PERCENT) / {8'h00, init};
      if (q > `SAR_PERCENT) q = `SAR_PERCENT;
      return q[7:0];
   endfunction : pct

   logic [7:0]  spare_pct_reg, spare_pct_next;
   logic [15:0] sel_init_reg, sel_init_next, sel_cur_reg, sel_cur_next;
   logic [15:0] sum_init_reg, sum_init_next, sum_cur_reg, sum_cur_next;
   logic [7:0]  life_pct_reg, life_pct_next;

   always_comb begin
      logic [7:0]  p;
      logic [71:0] used;
      p = 8'h00;
      used = 72'h0;
      spare_pct_next = 8'hff;
      sel_init_next  = 16'h0000;
      sel_cur_next   = 16'h0000;
      sum_init_next  = 16'h0000;
      sum_cur_next   = 16'h0000;
      for (int i = 0; i < NCHIPS; i++) begin
         p = pct(spare_cur[i*16 +: 16], spare_init[i*16 +: 16]);
         if (p < spare_pct_next) begin
            spare_pct_next = p;
            sel_init_next  = spare_init[i*16 +: 16];
            sel_cur_next   = spare_cur[i*16 +: 16];
         end
         sum_init_next = sum_init_next + spare_init[i*16 +: 16];
         sum_cur_next  = sum_cur_next + spare_cur[i*16 +: 16];
      end
      // life left: share of the erase budget not yet used
      if (erase_budget == 64'h0) life_pct_next = 8'(`SAR_PERCENT);
      else if (erase_total >= erase_budget) life_pct_next = 8'h00;
      else begin
         used = ({8'h00, erase_total} * 72'(`SAR_PERCENT))
                / {8'h00, erase_budget};
         life_pct_next = 8'(`SAR_PERCENT - used[23:0]);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         spare_pct_reg <= 8'h00;
         sel_init_reg  <= 16'h0000;
         sel_cur_reg   <= 16'h0000;
         sum_init_reg  <= 16'h0000;
         sum_cur_reg   <= 16'h0000;
         life_pct_reg  <= 8'h00;
      end else begin
         spare_pct_reg <= spare_pct_next;
         sel_init_reg  <= sel_init_next;
         sel_cur_reg   <= sel_cur_next;
         sum_init_reg  <= sum_init_next;
         sum_cur_reg   <= sum_cur_next;
         life_pct_reg  <= life_pct_next;
      end
   end

   assign ev.spare_pct = spare_pct_reg;
   assign ev.sel_init  = sel_init_reg;
   assign ev.sel_cur   = sel_cur_reg;
   assign ev.sum_init  = sum_init_reg;
   assign ev.sum_cur   = sum_cur_reg;
   assign ev.life_pct  = life_pct_reg;

   property p_spare_range;
      @(posedge sys_clk) disable iff (!arst_n)
      ##1 spare_pct_reg <= 8'h64 || spare_pct_reg == 8'hff;
   endproperty
   a_spare_range: assert property (p_spare_range)
      else $error("spare percentage above 100");

   property p_life_range;
      @(posedge sys_clk) disable iff (!arst_n)
      (erase_total >= erase_budget && erase_budget != 64'h0)
         |=> life_pct_reg == 8'h00;
   endproperty
   a_life_range: assert property (p_life_range)
      else $error("life not zero when budget is used up");
endmodule : sar_health_eval

/* File: verif/sar_flash_model.sv */
// flash management side: turns bench requests into event pulses
`timescale 1ns/1ns
module sar_flash_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   // requests in, the same bits registered one cycle later out
   input  wire logic [3:0] req,
   output      logic [3:0] evt
);
   logic [3:0] evt_reg;
   logic [3:0] evt_next;
   assign evt = evt_reg;
   always_comb evt_next = req;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         evt_reg <= 4'h0;
      else
         evt_reg <= evt_next;
   end
endmodule : sar_flash_model

/* File: verif/smart_attribute_reporter_test.sv */
// self-checking bench of the health attribute reporter
`timescale 1ns/1ns
module smart_attribute_reporter_test;
   logic sys_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]  htrans = 2'h0;
   logic        hreadyout, hresp;
   logic [3:0]  req = 4'h0, evt;
   logic [63:0] sp_init = {4{16'h00c8}}, sp_cur = {4{16'h00c8}};
   logic [63:0] er_tot = 64'h0, er_bud = 64'h0;
   logic [7:0]  rnd = 8'h1c, thr_s, thr_e, b [512];
   logic [7:0]  ts [4] = '{8'h00, 8'h65, 8'h00, 8'h00};
   logic [7:0]  te [4] = '{8'h64, 8'h00, 8'h65, 8'h01};
   int n_fail = 0, n_compared = 0, cyc = 0, cnt [4] = '{0, 0, 0, 0};
   always #20 sys_clk = ~sys_clk;
   sar_reporter u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ecc_corr_evt(evt[0]),
      .ecc_uncorr_evt(evt[1]), .flash_read_evt(evt[2]),
      .crc_err_evt(evt[3]), .spare_init(sp_init), .spare_cur(sp_cur),
      .erase_total(er_tot), .erase_budget(er_bud));
   sar_flash_model u_fm (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
      .evt(evt));
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr
   function automatic logic [7:0] life(input logic [63:0] t,
                                       input logic [63:0] u);
      logic [71:0] x;
      x = 72'h64;
      if (u != 64'h0 && t >= u) x = 72'h0;
      else if (u != 64'h0) x = 72'h64 - {8'h0, t} * 72'h64 / {8'h0, u};
      return x[7:0];
   endfunction : life
   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic cmd(input logic [7:0] f);
      bus(8'h00, 1'b1, {24'h0, f});
      bus(8'h04, 1'b1, 32'h4f);
      bus(8'h08, 1'b1, 32'hc2);
      bus(8'h0c, 1'b1, 32'he0);
      bus(8'h10, 1'b1, 32'hb0);
   endtask : cmd
   task automatic sector(input logic thr);
      logic [7:0] ids [6] = '{8'hc4, 8'he5, 8'hcb, 8'hcc, 8'he8, 8'hc7};
      logic [15:0] mn, sc;
      logic [63:0] v;
      int at;
      mn = 16'd200;
      sc = 16'h0;
      for (int i = 0; i < 512; i++) b[i] = 8'h0;
      b[0] = 8'h04;
      for (int c = 0; c < 4; c++) begin
         sc += sp_cur[16*c+:16];
         if (sp_cur[16*c+:16] < mn) mn = sp_cur[16*c+:16];
      end
      for (int r = 0; r < 6; r++) begin
         at = 2 + 12 * r;
         b[at] = ids[r];
         if (thr) begin
            b[at+1] = r == 0 ? thr_s : r == 1 ? thr_e : 8'h0;
            continue;
         end
         b[at+1] = r < 2 ? 8'h03 : 8'h02;
         b[at+3] = r == 0 ? 8'(mn / 2) :
                   r == 1 ? life(er_tot, er_bud) : 8'h64;
         v = r == 0 ? {sc, 16'd800, mn, 16'd200} :
             r == 1 ? er_tot : 64'(cnt[r-2]);
         for (int i = 0; i < 8; i++) b[at+4+i] = v[8*i+:8];
      end
      for (int i = 0; i < 511; i++) b[511] -= b[i];
      bus(8'h14, 1'b0, 32'h0);
      chk(q[0], 1'b1);
      for (int w = 0; w < 128; w++) begin
         bus(8'h18, 1'b0, 32'h0);
         chk(q, {b[4*w+3], b[4*w+2], b[4*w+1], b[4*w]});
      end
      bus(8'h14, 1'b0, 32'h0);
      chk(q[0], 1'b0);
   endtask : sector
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      for (int c = 0; c < 4; c++) begin
         rnd = lfsr(rnd);
         sp_cur[16*c+:16] <= 16'(rnd % 8'd100) * 16'd2;
      end
      er_tot <= {8{rnd}};
      er_bud <= 64'hffff_ffff_ffff_ffff;
      for (int i = 0; i < 200; i++) begin
         rnd = lfsr(rnd);
         req <= rnd[3:0];
         cnt[0] += int'(rnd[0] | rnd[1]);
         cnt[1] += int'(rnd[0]);
         cnt[2] += int'(rnd[2]);
         cnt[3] += int'(rnd[3]);
         @(posedge sys_clk);
      end
      req <= 4'h0;
      repeat (4) @(posedge sys_clk);
      cmd(8'hd0);
      sector(1'b0);
      $display("attribute data done");
      thr_s = lfsr(rnd);
      thr_e = rnd;
      bus(8'h1c, 1'b1, {24'h0, thr_s});
      bus(8'h20, 1'b1, {24'h0, thr_e});
      cmd(8'hd1);
      sector(1'b1);
      $display("threshold sector done");
      te[0] = life(er_tot, er_bud);
      te[2] = te[0] + 8'h01;
      for (int k = 0; k < 4; k++) begin
         if (k == 3) er_bud <= er_tot;
         bus(8'h1c, 1'b1, {24'h0, ts[k]});
         bus(8'h20, 1'b1, {24'h0, te[k]});
         cmd(8'hda);
         repeat (2) @(posedge sys_clk);
         bus(8'h04, 1'b0, 32'h0);
         chk(q, k > 0 ? 32'hf4 : 32'h4f);
         bus(8'h08, 1'b0, 32'h0);
         chk(q, k > 0 ? 32'h2c : 32'hc2);
      end
      $display("return status done");
      bus(8'h10, 1'b1, 32'ha0);
      bus(8'h14, 1'b0, 32'h0);
      chk(q[1:0], 2'h2);
      bus(8'h40, 1'b0, 32'h0);
      chk(q, 32'h0);
      chk(hresp, 1'b0);
      bus(8'h18, 1'b0, 32'h0);
      chk(q, 32'h0);
      cmd(8'hd5);
      bus(8'h14, 1'b0, 32'h0);
      chk(q[1:0], 2'h2);
      $display("refusals done");
      final_report();
   end
endmodule : smart_attribute_reporter_test
